// ===== verilog/ewbs_pkg.sv
// Purpose: Shared constants and types for the write busy/ready status block.
// Assumes: Byte organised array, 7 address bits, 8 data bits per write command.
// Notes: Summary of operation is listed below.
// Summary of operation
// - While the internal write runs, the array refuses every access.
// - Internal write starts when select drops after a complete write-type command.
// - Selected during a running write, the output is driven low.
// - Once the write has finished, the output is driven high while selected.
// - Status needs no serial clock edges; it follows select alone.
// - After ready, the output reads high on every select until cleared.
// - A start bit clocked in clears the ready indication.
// - Select low resets the instruction register; commands restart with start bit.
package ewbs_pkg;

	// System clock rate and the self-timed write length.
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned WRITE_TIME_MS = 10;
	localparam int unsigned WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned TMR_W = 20;

	// Command field layout after the start bit.
	localparam int unsigned HDR_BITS = 9;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned CNT_W = 5;
	localparam logic [CNT_W-1:0] HDR_LAST = CNT_W'(HDR_BITS - 1);
	localparam logic [CNT_W-1:0] FULL_LAST = CNT_W'(HDR_BITS + DATA_BITS - 1);

	// Opcodes and the sub-codes of the special group.
	localparam logic [1:0] OP_SPECIAL = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;

	// Bit positions of the opcode and sub-code within the nine header bits.
	localparam int unsigned OP_MSB = HDR_BITS - 1;
	localparam int unsigned OP_LSB = HDR_BITS - 2;
	localparam int unsigned SUB_MSB = HDR_BITS - 3;
	localparam int unsigned SUB_LSB = HDR_BITS - 4;

	// Receive states of the serial side.
	typedef enum logic [1:0] {
		EWBS_IDLE = 2'b00,
		EWBS_SHIFT = 2'b01,
		EWBS_DONE = 2'b10
	} ewbs_rx_t;

	// Events carried from the serial side as toggles.
	typedef struct packed {
		logic start_tgl;
		logic write_tgl;
	} ewbs_ev_t;

endpackage : ewbs_pkg

// ===== verilog/ewbs_sync.sv
// Purpose: Two flip-flop synchroniser for a group of level or toggle signals.
// Assumes: Each bit changes independently; no bus coherence is implied.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module ewbs_sync #(
	parameter int unsigned W = 1
) (
	// Destination clock.
	input wire logic clk,
	input wire logic ce,
	// Asynchronous data in, synchronised data out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// Two stages give metastability time to settle.
	always_ff @(posedge clk) begin
		if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : ewbs_sync

// ===== verilog/ewbs_core.sv
// Purpose: Ready/busy reporting for a serial nonvolatile memory's self-timed write.
// Assumes: Host launches select and data in step with serial_clock falling edges.
// Notes: Serial side runs on serial_clock; timing and status run on clk_sys.
`timescale 1ns/10ps
module ewbs_core #(
	parameter int unsigned WRITE_CYCLES = ewbs_pkg::WRITE_CYCLES
) (
	// System clock, reset and freeze.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Serial port from the host.
	input wire logic serial_clock,
	input wire logic chip_select,
	input wire logic serial_data_in,
	// Status output pin as data and enable.
	output logic data_out_o,
	output logic data_out_oe,
	// Internal write in progress, for the array.
	output logic busy_o
);

	// Serial side state.
	ewbs_pkg::ewbs_rx_t rx_q;
	logic [ewbs_pkg::CNT_W-1:0] cnt_q;
	logic [ewbs_pkg::HDR_BITS-2:0] hdr_q;
	logic need_data_q;
	ewbs_pkg::ewbs_ev_t ev_q;
	logic link_rst;
	logic link_busy;
	logic [ewbs_pkg::HDR_BITS-1:0] hdr_d;
	logic [1:0] op_d;
	logic [1:0] sub_d;
	logic erase_kind;
	logic write_kind;

	// System side state.
	logic cs_s;
	ewbs_pkg::ewbs_ev_t ev_s;
	logic cs_prev_q;
	ewbs_pkg::ewbs_ev_t ev_prev_q;
	logic armed_q;
	logic busy_q;
	logic ready_q;
	logic [ewbs_pkg::TMR_W-1:0] tmr_q;
	logic cs_rise;
	logic cs_fall;
	logic start_ev;
	logic write_ev;
	logic write_end;
	logic start_write;

	// Reset and busy level brought into the serial clock domain.
	ewbs_sync #(.W(2)) u_link_sync (
		.clk(serial_clock),
		.ce(1'b1),
		.d({rst, busy_q}),
		.q({link_rst, link_busy})
	);

	// Select and event toggles brought into the system clock domain.
	ewbs_sync #(.W(3)) u_sys_sync (
		.clk(clk_sys),
		.ce(ce),
		.d({chip_select, ev_q}),
		.q({cs_s, ev_s})
	);

	// Header as it stands after the current bit is shifted in.
	assign hdr_d = {hdr_q, serial_data_in};

	// Opcode and sub-code as they stand at the last header bit.
	assign op_d = hdr_d[ewbs_pkg::OP_MSB:ewbs_pkg::OP_LSB];
	assign sub_d = hdr_d[ewbs_pkg::SUB_MSB:ewbs_pkg::SUB_LSB];

	// Erase forms need no data byte; write forms wait for one.
	assign erase_kind = (op_d == ewbs_pkg::OP_ERASE) ||
			(op_d == ewbs_pkg::OP_SPECIAL && sub_d == ewbs_pkg::SUB_ERASE_ALL);
	assign write_kind = (op_d == ewbs_pkg::OP_WRITE) ||
			(op_d == ewbs_pkg::OP_SPECIAL && sub_d == ewbs_pkg::SUB_WRITE_ALL);

	// Serial receiver: start bit, opcode, address, then data for writes.
	always_ff @(posedge serial_clock) begin
		if (link_rst) begin
			rx_q <= ewbs_pkg::EWBS_IDLE;
			cnt_q <= '0;
			hdr_q <= '0;
			need_data_q <= 1'b0;
			ev_q <= '0;
		end else if (!chip_select) begin
			rx_q <= ewbs_pkg::EWBS_IDLE;
			cnt_q <= '0;
		end else begin
			unique case (rx_q)
				ewbs_pkg::EWBS_IDLE: begin
					// A busy array takes no command, so no start bit is seen.
					if (serial_data_in && !link_busy) begin
						ev_q.start_tgl <= ~ev_q.start_tgl;
						rx_q <= ewbs_pkg::EWBS_SHIFT;
						cnt_q <= '0;
						need_data_q <= 1'b0;
					end
				end
				ewbs_pkg::EWBS_SHIFT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q < ewbs_pkg::HDR_LAST) begin
						hdr_q <= hdr_d[ewbs_pkg::HDR_BITS-2:0];
					end else if (cnt_q == ewbs_pkg::HDR_LAST) begin
						hdr_q <= hdr_d[ewbs_pkg::HDR_BITS-2:0];
						// Other codes carry no write and end the frame here.
						if (erase_kind) begin
							ev_q.write_tgl <= ~ev_q.write_tgl;
							rx_q <= ewbs_pkg::EWBS_DONE;
						end else if (write_kind) begin
							need_data_q <= 1'b1;
						end else begin
							rx_q <= ewbs_pkg::EWBS_DONE;
						end
					end else if (cnt_q == ewbs_pkg::FULL_LAST) begin
						if (need_data_q) begin
							ev_q.write_tgl <= ~ev_q.write_tgl;
						end
						rx_q <= ewbs_pkg::EWBS_DONE;
					end
				end
				ewbs_pkg::EWBS_DONE: begin
					// Further bits are ignored until select drops.
					rx_q <= ewbs_pkg::EWBS_DONE;
				end
				default: begin
					rx_q <= ewbs_pkg::EWBS_IDLE;
				end
			endcase
		end
	end

	// Edges of the synchronised select and of the event toggles.
	assign cs_rise = cs_s && !cs_prev_q;
	assign cs_fall = !cs_s && cs_prev_q;
	assign start_ev = ev_s.start_tgl != ev_prev_q.start_tgl;
	assign write_ev = ev_s.write_tgl != ev_prev_q.write_tgl;
	assign write_end = busy_q && (tmr_q == '0);

	// The write event and the drop of select can land here in one cycle when the host
	// lowers select right after its last clock, so the event counts directly as well.
	assign start_write = cs_fall && (armed_q || write_ev) && !busy_q;

	// History of the synchronised inputs for edge detection.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cs_prev_q <= 1'b0;
			ev_prev_q <= '0;
		end else if (ce) begin
			cs_prev_q <= cs_s;
			ev_prev_q <= ev_s;
		end
	end

	// A complete write command is armed only for the frame it arrived in.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (ce) begin
			if (write_ev) begin
				armed_q <= 1'b1; // Set wins over a select edge in the same cycle.
			end else if (cs_rise || cs_fall) begin
				armed_q <= 1'b0;
			end
		end
	end

	// Self-timed write: select falling on an armed command starts the timer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_q <= 1'b0;
			tmr_q <= '0;
		end else if (ce) begin
			if (start_write) begin
				busy_q <= 1'b1;
				tmr_q <= ewbs_pkg::TMR_W'(WRITE_CYCLES - 1);
			end else if (write_end) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				tmr_q <= tmr_q - 1'b1;
			end
		end
	end

	// Ready holds until a start bit; the end of a write wins over a clear.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else if (ce) begin
			if (write_end) begin
				ready_q <= 1'b1;
			end else if (start_ev) begin
				ready_q <= 1'b0;
			end
		end
	end

	// Status pin follows select alone; no serial clock edge is needed.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_out_o <= 1'b0;
			data_out_oe <= 1'b0;
		end else if (ce) begin
			data_out_o <= ready_q && !busy_q;
			data_out_oe <= cs_s && (busy_q || ready_q);
		end
	end

	// Busy level for the array, registered so the pin and the array agree in time.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_o <= 1'b0;
		end else if (ce) begin
			busy_o <= busy_q;
		end
	end

endmodule : ewbs_core

// ===== tb/ewbs_core_asserts.sv
// Purpose: Concurrent checks on the status pin and the write timer.
// Assumes: The bench holds select steady for several system cycles.
// Notes: Select is asynchronous, so windows allow for the sync delay.
`timescale 1ns/10ps
module ewbs_core_asserts #(
	parameter int unsigned WRITE_CYCLES = 50
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Watched pins.
	input wire logic chip_select,
	input wire logic data_out_o,
	input wire logic data_out_oe,
	input wire logic busy_o
);
	int unsigned busy_len_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Counts the cycles of one write; a frozen clock must not stretch it.
	always_ff @(posedge clk_sys) begin
		if (rst || !busy_o) busy_len_q <= 0;
		else if (ce) busy_len_q <= busy_len_q + 1;
	end
	a_float_unsel: assert property (!chip_select [*6] |-> !data_out_oe)
		else $error("status pin driven while deselected");
	a_float_nothing: assert property ((!busy_o && !data_out_o) [*4] |-> !data_out_oe)
		else $error("status pin driven with nothing to report");
	a_busy_low: assert property (data_out_oe && busy_o |-> !data_out_o)
		else $error("ready shown during write");
	a_busy_drives: assert property (chip_select [*6] ##0 busy_o [*3] |-> data_out_oe)
		else $error("busy not shown while selected");
	a_ready_after: assert property ($fell(busy_o) |-> ##[1:3] data_out_o)
		else $error("ready late after write");
	a_write_length: assert property ($fell(busy_o) |-> busy_len_q == WRITE_CYCLES)
		else $error("write length wrong");
	a_start_on_drop: assert property ($rose(busy_o) |-> !$past(chip_select, 3))
		else $error("write began while selected");
	a_ready_drives: assert property (chip_select [*6] ##0 data_out_o [*3] |-> data_out_oe)
		else $error("ready not shown while selected");
	a_clear_sel: assert property ($fell(data_out_o) |-> $past(chip_select, 4))
		else $error("ready cleared without a start bit");
endmodule : ewbs_core_asserts
bind ewbs_core ewbs_core_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_sys(clk_sys),
	.rst(rst), .ce(ce), .chip_select(chip_select), .data_out_o(data_out_o),
	.data_out_oe(data_out_oe), .busy_o(busy_o));

// ===== tb/ewbs_host_model.sv
// Purpose: Host side of the three-wire serial port.
// Assumes: Link clock of 15 ns that stands still outside frames and the two-edge select-low gaps before them.
// Notes: Released data toggles so a stale level is never mistaken for data.
`timescale 1ns/10ps
module ewbs_host_model (
	// Serial port toward the device.
	output logic serial_clock,
	output logic chip_select,
	output logic serial_data_in
);
	initial begin
		serial_clock = 1'b0;
		chip_select = 1'b0;
		serial_data_in = 1'b1;
	end
	// One bit per rising edge; data changes only while the clock is low.
	task automatic bit_out(input logic b);
		serial_data_in = b;
		#7.5 serial_clock = 1'b1;
		#7.5 serial_clock = 1'b0;
	endtask : bit_out
	task automatic select(input logic v);
		chip_select = v;
	endtask : select
	// Low-select edges reset the receiver and refresh its view of busy.
	task automatic gap();
		chip_select = 1'b0;
		bit_out(~serial_data_in);
		bit_out(~serial_data_in);
	endtask : gap
	task automatic frame(input logic [17:0] v);
		gap();
		chip_select = 1'b1;
		for (int i = 17; i >= 0; i--) bit_out(v[i]);
		chip_select = 1'b0;
		serial_data_in = ~serial_data_in;
	endtask : frame
	// A lone start bit clears ready; select stays up a while before dropping.
	task automatic dummy_start();
		gap();
		chip_select = 1'b1;
		bit_out(1'b1);
		#100 gap();
	endtask : dummy_start
endmodule : ewbs_host_model

// ===== tb/tb.sv
// Purpose: Self-checking bench for write busy/ready reporting.
// Assumes: A short write timer so each write takes under a microsecond.
// Notes: The host model owns the serial pins; the bench owns clock and reset.
`timescale 1ns/10ps
module tb;
	localparam int unsigned WCYC = 50;
	logic clk_sys, rst, ce, serial_clock, chip_select, serial_data_in;
	logic data_out_o, data_out_oe, busy_o;
	int bad_count = 0;
	int checks_done = 0;
	int busy_cnt = 0;
	ewbs_core #(.WRITE_CYCLES(WCYC)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.serial_clock(serial_clock), .chip_select(chip_select), .serial_data_in(serial_data_in),
		.data_out_o(data_out_o), .data_out_oe(data_out_oe), .busy_o(busy_o));
	ewbs_host_model u_host (.serial_clock(serial_clock), .chip_select(chip_select),
		.serial_data_in(serial_data_in));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Busy time is measured here, apart from the design's own timer; frozen cycles do not count.
	always @(posedge clk_sys) if (busy_o === 1'b1 && ce === 1'b1) busy_cnt++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wait_clk
	// Starts a write, polls with select held and no link clock.
	// A non-zero freeze holds the clock enable low for that many cycles mid-write.
	task automatic do_write(input logic [17:0] cmd, input int frz);
		busy_cnt = 0;
		u_host.frame(cmd);
		wait_clk(12);
		chk(busy_o, 1'b1);
		u_host.select(1'b1);
		wait_clk(8);
		chk({data_out_oe, data_out_o}, 2'h2);
		if (frz > 0) begin
			ce = 1'b0;
			wait_clk(frz);
			chk({busy_o, data_out_oe, data_out_o}, 3'h6);
			ce = 1'b1;
		end
		for (int i = 0; i < 200 && busy_o === 1'b1; i++) wait_clk(1);
		wait_clk(4);
		chk({data_out_oe, data_out_o}, 2'h3);
		chk(busy_cnt, WCYC);
		u_host.select(1'b0);
	endtask : do_write
	task automatic t_poll();
		wait_clk(8);
		chk(data_out_oe, 1'b0);
		for (int i = 0; i < 2; i++) begin
			u_host.select(1'b1);
			wait_clk(8);
			chk({data_out_oe, data_out_o}, 2'h3);
			u_host.select(1'b0);
			wait_clk(8);
		end
		$display("t_poll done");
	endtask : t_poll
	task automatic t_clear();
		u_host.dummy_start();
		wait_clk(8);
		chk({data_out_oe, data_out_o, busy_o}, 3'h0);
		u_host.select(1'b1);
		wait_clk(8);
		chk(data_out_oe, 1'b0);
		u_host.select(1'b0);
		// The cut dummy frame must leave the receiver ready for a full command.
		do_write({1'h1, 2'h1, 7'h05, 8'h5a}, 20);
		$display("t_clear done");
	endtask : t_clear
	task automatic t_ops();
		do_write({1'h1, 2'h1, 7'h15, 8'ha5}, 0);
		do_write({1'h1, 2'h3, 7'h2a, 8'h00}, 0);
		do_write({1'h1, 2'h0, 7'h20, 8'h3c}, 0);
		$display("t_ops done");
	endtask : t_ops
	task automatic t_refuse();
		u_host.frame({1'h1, 2'h2, 7'h01, 8'hff});
		wait_clk(20);
		chk(busy_o, 1'b0);
		$display("t_refuse done");
	endtask : t_refuse
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		// Four link edges under reset: the serial side needs three to see it.
		u_host.gap();
		u_host.gap();
		wait_clk(12);
		rst = 1'b0;
		wait_clk(4);
		t_ops();
		t_poll();
		t_clear();
		t_refuse();
		stop_test();
	end
	initial begin
		#100us;
		bad_count++;
		stop_test();
	end
endmodule : tb
